// *** design/gcss_map.svh ***
// Register offsets, field positions, reset values and timing counts of the gauge coil scan sequencer.
`ifndef GCSS_MAP_SVH
`define GCSS_MAP_SVH
`define GCSS_OFF_MAG0       12'h000
`define GCSS_OFF_MAG11      12'h02C
`define GCSS_OFF_DIR0       12'h040
`define GCSS_OFF_DIR5       12'h054
`define GCSS_OFF_ENABLE     12'h060
`define GCSS_OFF_SCAN       12'h064
`define GCSS_BIT_CLK_SEL_LO 0
`define GCSS_BIT_CLK_SEL_HI 1
`define GCSS_BIT_SYNC_CLEAR 3
`define GCSS_BIT_SYNC_FLAG  4
`define GCSS_BIT_SYNC_IRQEN 5
`define GCSS_BIT_AUTO_MODE  6
`define GCSS_BIT_SCAN_START 7
`define GCSS_RST_SCAN       8'h00
`define GCSS_RST_ENABLE     6'h3F
`define GCSS_DIV_BASE       13'h0200
`define GCSS_SETTLE_START   13'h0040
`define GCSS_SH_CLOSE       13'h0080
`define GCSS_SYNC_COIL      4'hA
`define GCSS_LAST_COIL      4'hB
`endif

// *** design/gcss_pkg.sv ***
// Types shared by the gauge coil scan sequencer.
package gcss_pkg;
	typedef enum logic [1:0] {GCSS_IDLE, GCSS_MOVE, GCSS_CONVERT, GCSS_SETTLE} gcss_state_e;
	typedef struct packed {
		logic       sampleHoldClose;
		logic [3:0] coilIndex;
		logic [7:0] converterData;
		logic       coilDirection;
		logic       coilEnable;
	} gcss_coil_drive_s;
endpackage

// *** design/gcss_gauge_coil_scan_sequencer.sv ***
// Gauge coil scan sequencer with AXI4-Lite register slave.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "gcss_map.svh"
module gcss_gauge_coil_scan_sequencer (
	// Clock and reset.
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	// AXI4-Lite write channels.
	input  wire logic [11:0]               s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [11:0]               s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Converter and coil driver side, and sync interrupt.
	output gcss_pkg::gcss_coil_drive_s     coilDrive,
	output logic                           syncIrq
);
	import gcss_pkg::*;

	logic [7:0]  magMaster [12];
	logic [7:0]  magSlave [12];
	logic [11:0] dirMaster;
	logic [11:0] dirSlave;
	logic [11:0] magWritten;
	logic [5:0]  gaugeEnable;
	logic        scanStart, autoMode, syncIrqEnable, syncFlag, syncSeen;
	logic [1:0]  clkSel;
	logic [12:0] prescale;
	logic [3:0]  coil;
	gcss_state_e state;
	logic        awHeld, wHeld;
	logic [11:0] awAddr;
	logic [31:0] wData;
	logic [3:0]  wStrb;

	logic [7:0]  next_magMaster [12];
	logic [7:0]  next_magSlave [12];
	logic [11:0] next_dirMaster, next_dirSlave, next_magWritten;
	logic [5:0]  next_gaugeEnable;
	logic        next_scanStart, next_autoMode, next_syncIrqEnable, next_syncFlag, next_syncSeen;
	logic [1:0]  next_clkSel;
	logic [12:0] next_prescale;
	logic [3:0]  next_coil;
	gcss_state_e next_state;
	logic        next_awHeld, next_wHeld, next_bvalid, next_rvalid;
	logic [11:0] next_awAddr;
	logic [31:0] next_wData, next_rdata;
	logic [3:0]  next_wStrb;
	logic [1:0]  next_bresp, next_rresp;
	logic [12:0] divLimit;
	logic        tick, doWrite, doRead, startReq;
	logic [3:0]  wIdx;
	logic [7:0]  scanRead;

	always_comb begin
		divLimit = 13'(`GCSS_DIV_BASE << clkSel);
	end

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign syncIrq       = syncIrqEnable && syncFlag;
	assign scanRead = {scanStart, autoMode, syncIrqEnable, syncFlag, 2'b00, clkSel};

	always_comb begin
		next_magMaster = magMaster;
		next_magSlave = magSlave;
		next_dirMaster = dirMaster;
		next_dirSlave = dirSlave;
		next_magWritten = magWritten;
		next_gaugeEnable = gaugeEnable;
		next_scanStart = scanStart;
		next_autoMode = autoMode;
		next_syncIrqEnable = syncIrqEnable;
		next_syncFlag = syncFlag;
		next_syncSeen = syncSeen;
		next_clkSel = clkSel;
		next_prescale = prescale;
		next_coil = coil;
		next_state = state;
		next_awHeld = awHeld || (s_axi_awvalid && s_axi_awready);
		next_wHeld = wHeld || (s_axi_wvalid && s_axi_wready);
		next_awAddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awAddr;
		next_wData = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wData;
		next_wStrb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wStrb;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		doWrite = awHeld && wHeld && !s_axi_bvalid;
		doRead = s_axi_arvalid && s_axi_arready;
		wIdx = 4'(awAddr[5:2]);
		startReq = 1'b0;
		tick = 1'b0;

		if (state != GCSS_IDLE) begin
			if (prescale >= divLimit - 13'h0001) begin
				next_prescale = 13'h0000;
				tick = 1'b1;
			end else begin
				next_prescale = prescale + 13'h0001;
			end
		end

		// Phases within a coil update period.
		// Close hold after conversion, then settle.
		unique case (state)
			GCSS_IDLE: begin
			end
			GCSS_MOVE: begin
				next_state = GCSS_CONVERT;
			end
			GCSS_CONVERT: begin
				if (prescale == `GCSS_SETTLE_START) begin
					next_state = GCSS_SETTLE;
				end
			end
			GCSS_SETTLE: begin
			end
		endcase

		if (tick) begin
			if (coil == `GCSS_LAST_COIL) begin
				next_coil = 4'h0;
				next_state = autoMode ? GCSS_MOVE : GCSS_IDLE;
			end else begin
				next_coil = coil + 4'h1;
				next_state = GCSS_MOVE;
			end
			if (coil == `GCSS_SYNC_COIL - 4'h1) begin
				next_syncFlag = 1'b1;
				next_scanStart = 1'b0;
			end
			if (next_coil[0] == 1'b0 && next_state == GCSS_MOVE) begin
				if (!autoMode || (magWritten[next_coil] && magWritten[next_coil + 4'h1])) begin
					next_magSlave[next_coil] = magMaster[next_coil];
					next_magSlave[next_coil + 4'h1] = magMaster[next_coil + 4'h1];
					next_dirSlave[next_coil] = dirMaster[next_coil];
					next_dirSlave[next_coil + 4'h1] = dirMaster[next_coil + 4'h1];
					next_magWritten[next_coil] = 1'b0;
					next_magWritten[next_coil + 4'h1] = 1'b0;
				end
			end
		end

		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = 2'b00;
			if (awAddr <= `GCSS_OFF_MAG11) begin
				if (wStrb[0]) begin
					next_magMaster[wIdx] = wData[7:0];
					next_magWritten[wIdx] = 1'b1;
				end
			end else if (awAddr >= `GCSS_OFF_DIR0 && awAddr <= `GCSS_OFF_DIR5) begin
				if (wStrb[0]) begin
					next_dirMaster[{wIdx[2:0], 1'b0}] = wData[0];
					next_dirMaster[{wIdx[2:0], 1'b1}] = wData[1];
				end
			end else if (awAddr == `GCSS_OFF_ENABLE) begin
				if (wStrb[0]) begin
					next_gaugeEnable = wData[5:0];
				end
			end else if (awAddr == `GCSS_OFF_SCAN) begin
				if (wStrb[0]) begin
					next_autoMode = wData[`GCSS_BIT_AUTO_MODE];
					next_syncIrqEnable = wData[`GCSS_BIT_SYNC_IRQEN];
					next_clkSel = wData[`GCSS_BIT_CLK_SEL_HI:`GCSS_BIT_CLK_SEL_LO];
					if (wData[`GCSS_BIT_SYNC_CLEAR] && syncSeen && next_syncFlag) begin
						next_syncFlag = tick && coil == `GCSS_SYNC_COIL - 4'h1;
						next_syncSeen = 1'b0;
					end
					// Ignored while set or when the same write sets the automatic mode bit.
					if (wData[`GCSS_BIT_SCAN_START] && !scanStart && !wData[`GCSS_BIT_AUTO_MODE]) begin
						startReq = 1'b1;
					end
				end
			end else begin
				next_bresp = 2'b10;
			end
		end

		if (startReq) begin
			next_scanStart = 1'b1;
			next_magSlave = magMaster;
			next_dirSlave = dirMaster;
			next_magWritten = 12'h000;
			next_coil = 4'h0;
			next_prescale = 13'h0000;
			next_state = GCSS_MOVE;
		end else if (state == GCSS_IDLE && next_autoMode && !autoMode) begin
			next_coil = 4'h0;
			next_prescale = 13'h0000;
			next_state = GCSS_MOVE;
		end

		if (doRead) begin
			next_rvalid = 1'b1;
			next_rresp = 2'b00;
			next_rdata = 32'h0000_0000;
			if (s_axi_araddr <= `GCSS_OFF_MAG11) begin
				next_rdata[7:0] = magSlave[4'(s_axi_araddr[5:2])];
			end else if (s_axi_araddr >= `GCSS_OFF_DIR0 && s_axi_araddr <= `GCSS_OFF_DIR5) begin
				next_rdata[1:0] = {dirSlave[{s_axi_araddr[4:2], 1'b1}], dirSlave[{s_axi_araddr[4:2], 1'b0}]};
			end else if (s_axi_araddr == `GCSS_OFF_ENABLE) begin
				next_rdata[5:0] = gaugeEnable;
			end else if (s_axi_araddr == `GCSS_OFF_SCAN) begin
				next_rdata[7:0] = scanRead;
				if (syncFlag) begin
					next_syncSeen = 1'b1;
				end
			end else begin
				next_rresp = 2'b10;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 12; i++) begin
				magMaster[i] <= 8'h00;
				magSlave[i] <= 8'h00;
			end
			dirMaster <= 12'h000;
			dirSlave <= 12'h000;
			magWritten <= 12'h000;
			gaugeEnable <= `GCSS_RST_ENABLE;
			{scanStart, autoMode, syncIrqEnable, syncFlag} <= 4'h0;
			syncSeen <= 1'b0;
			clkSel <= 2'b00;
			prescale <= 13'h0000;
			coil <= 4'h0;
			state <= GCSS_IDLE;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 12'h000;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
			coilDrive <= '0;
		end else begin
			magMaster <= next_magMaster;
			magSlave <= next_magSlave;
			dirMaster <= next_dirMaster;
			dirSlave <= next_dirSlave;
			magWritten <= next_magWritten;
			gaugeEnable <= next_gaugeEnable;
			scanStart <= next_scanStart;
			autoMode <= next_autoMode;
			syncIrqEnable <= next_syncIrqEnable;
			syncFlag <= next_syncFlag;
			syncSeen <= next_syncSeen;
			clkSel <= next_clkSel;
			prescale <= next_prescale;
			coil <= next_coil;
			state <= next_state;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			coilDrive.coilIndex <= next_coil;
			coilDrive.converterData <= next_magSlave[next_coil];
			coilDrive.coilDirection <= next_dirSlave[next_coil];
			coilDrive.coilEnable <= next_gaugeEnable[next_coil[3:1]];
			coilDrive.sampleHoldClose <= (next_state == GCSS_SETTLE) && next_gaugeEnable[next_coil[3:1]];
		end
	end
endmodule
`default_nettype wire

// *** dv/gcss_monitor.sv ***
// Port checker of the gauge coil scan sequencer.
`timescale 1ns/10ps
`default_nettype none
module gcss_monitor (
	// Clock and reset.
	input wire logic                      clk,
	input wire logic                      sys_rst,
	// Read handshake.
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic                      s_axi_rvalid,
	// Coil side.
	input wire gcss_pkg::gcss_coil_drive_s coilDrive
);
	import gcss_pkg::*;
	logic [3:0]  lastIdx, next_lastIdx;
	logic [15:0] dwell, next_dwell;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	always_comb begin
		next_lastIdx = coilDrive.coilIndex;
		next_dwell = (coilDrive.coilIndex != lastIdx) ? 16'h0 : dwell + {15'h0, dwell != 16'hFFFF};
	end
	always_ff @(posedge clk) begin
		lastIdx <= sys_rst ? 4'h0 : next_lastIdx;
		dwell <= sys_rst ? 16'hFFFF : next_dwell;
	end
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	chk_coil_range: assert property (coilDrive.coilIndex <= 4'hB)
		else $error("coil index out of range");
	chk_coil_order: assert property (coilDrive.coilIndex != lastIdx |->
		coilDrive.coilIndex == lastIdx + 4'h1 || coilDrive.coilIndex == 4'h0)
		else $error("coil order broken");
	chk_hold_enabled: assert property (coilDrive.sampleHoldClose |-> coilDrive.coilEnable)
		else $error("disabled gauge driven");
	chk_hold_open: assert property (coilDrive.coilIndex != lastIdx |-> !coilDrive.sampleHoldClose)
		else $error("hold closed while advancing");
	chk_period_min: assert property (coilDrive.coilIndex != lastIdx |-> dwell >= 16'h01FF)
		else $error("coil period too short");
	chk_level_steady: assert property (coilDrive.sampleHoldClose && $past(coilDrive.sampleHoldClose) |->
		$stable(coilDrive.converterData) && $stable(coilDrive.coilDirection))
		else $error("level moved while held");
	chk_settle_length: assert property ($rose(coilDrive.sampleHoldClose) |=> coilDrive.sampleHoldClose[*8])
		else $error("settle too short");
endmodule
bind gcss_gauge_coil_scan_sequencer gcss_monitor i_mon (.clk(clk), .sys_rst(sys_rst),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.coilDrive(coilDrive));
`default_nettype wire

// *** dv/gcss_coil_driver_model.sv ***
// Behavioural model of the shared converter and coil hold drivers.
`timescale 1ns/10ps
`default_nettype none
module gcss_coil_driver_model (
	// Clock and drive from the sequencer.
	input wire logic                       clk,
	input wire gcss_pkg::gcss_coil_drive_s coilDrive,
	// Level held per coil, direction above magnitude.
	output logic [11:0][8:0]               coilLevel
);
	import gcss_pkg::*;
	initial coilLevel = '0;
	// Each coil keeps the level seen while its hold switch is closed.
	always @(posedge clk) begin
		if (coilDrive.sampleHoldClose && coilDrive.coilIndex < 4'hC) begin
			coilLevel[coilDrive.coilIndex] <= {coilDrive.coilDirection, coilDrive.converterData};
		end
	end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking testbench of the gauge coil scan sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import gcss_pkg::*;
	logic clk = 1'b0, sysRst = 1'b1;
	logic [11:0] awAddr = 12'h0, arAddr = 12'h0;
	logic [31:0] wData = 32'h0, rData, v;
	logic [1:0] bResp, rResp, r;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid, syncIrq;
	gcss_coil_drive_s coilDrive;
	logic [11:0][8:0] lvl;
	int fails = 0, numChecks = 0, cycles = 0;
	always #4 clk = ~clk;
	gcss_gauge_coil_scan_sequencer i_dut (.clk(clk), .sys_rst(sysRst), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.coilDrive(coilDrive), .syncIrq(syncIrq));
	gcss_coil_driver_model i_coils (.clk(clk), .coilDrive(coilDrive), .coilLevel(lvl));
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] pend;
		logic [1:0] tk;
		pend = 2'b11;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		do begin
			@(negedge clk);
			tk = {awReady, wReady};
			@(posedge clk);
			if (tk[1]) awValid <= 1'b0;
			if (tk[0]) wValid <= 1'b0;
			pend = pend & ~tk;
		end while (pend != 2'b00);
		do @(negedge clk); while (bValid !== 1'b1);
		r = bResp;
		@(posedge clk);
		bReady <= 1'b1;
		@(posedge clk);
		bReady <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		arAddr <= a;
		arValid <= 1'b1;
		do @(negedge clk); while (arReady !== 1'b1);
		@(posedge clk);
		arValid <= 1'b0;
		do @(negedge clk); while (rValid !== 1'b1);
		v = rData;
		r = rResp;
		@(posedge clk);
		rReady <= 1'b1;
		@(posedge clk);
		rReady <= 1'b0;
	endtask
	task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		check(name, exp, v);
	endtask
	task automatic waitCoil(input logic [3:0] idx);
		do @(negedge clk); while (coilDrive.coilIndex !== idx);
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		rdc("scan", 12'h064, 32'h0);
		rdc("enable", 12'h060, 32'h3F);
		rd(12'h100);
		check("rresp", 32'h2, {30'h0, r});
		wr(12'h100, 32'hFF);
		check("bresp", 32'h2, {30'h0, r});
		$display("Test registers done");
		for (int g = 0; g < 6; g++) wr(12'h040 + 12'(g * 4), 32'h3);
		for (int i = 0; i < 12; i++) wr(12'(i * 4), 32'h20 + 32'(i));
		wr(12'h060, 32'h3E);
		wr(12'h064, 32'h80);
		rdc("start", 12'h064, 32'h80);
		waitCoil(4'hA);
		rdc("flag", 12'h064, 32'h10);
		wr(12'h064, 32'h20);
		check("irq", 32'h1, {31'h0, syncIrq});
		wr(12'h064, 32'h28);
		rdc("clear", 12'h064, 32'h20);
		check("irq off", 32'h0, {31'h0, syncIrq});
		waitCoil(4'hB);
		repeat (600) @(posedge clk);
		for (int i = 0; i < 12; i++) check("level", i < 2 ? 32'h0 : 32'h20 + 32'(i), {24'h0, lvl[i][7:0]});
		check("dir", 32'h3, {30'h0, lvl[3][8], lvl[2][8]});
		wr(12'h008, 32'h99);
		repeat (600) @(posedge clk);
		check("halt", 32'h22, {24'h0, lvl[2][7:0]});
		$display("Test manual done");
		wr(12'h060, 32'h3F);
		wr(12'h000, 32'h77);
		wr(12'h064, 32'h40);
		waitCoil(4'hB);
		waitCoil(4'h2);
		check("one", 32'h2220, {16'h0, lvl[2][7:0], lvl[0][7:0]});
		wr(12'h004, 32'h78);
		wr(12'h00C, 32'h33);
		waitCoil(4'hB);
		waitCoil(4'h4);
		check("both", 32'h78773399, {lvl[1][7:0], lvl[0][7:0], lvl[3][7:0], lvl[2][7:0]});
		$display("Test auto done");
		conclude();
	end
endmodule
`default_nettype wire
